// *** core/pagtm_port_a.sv ***
// port a: direction and data registers, read-back and timer/pattern pin muxing
// Contract
// - direction bit 1 makes its pin an output, 0 an input unless the timer owns the pin, per pin.
// - direction register is write-only; reading its address returns all ones.
// - reset and hardware standby clear the direction register to zero.
// - software standby keeps direction, so output pins keep driving.
// - data read returns the latch bit where the direction bit is 1.
// - data read returns the pin level where the pin is an input.
// - data latch cleared by reset and hardware standby, kept in software standby.
// - pin 7 drives channel 2 B compare when its B select is 1..3.
// - unowned pin: dir 0 input, dir 1 drives latch or pattern bit.
// - pins 7 and 5 feed B capture when select top bit 1 and pwm 0.
// - pin 6 drives channel 2 A compare under pwm or A select 1..3.
// - pins 6 and 4 feed A capture whenever A select top bit is 1.
// - pins 5 and 4 follow channel 1 B and A selection likewise.
// - pin 4 drives channel 1 A compare under pwm or A select 1..3.
`timescale 1ns/1ps
`default_nettype none

module pagtm_port_a
(
   // clock and reset
   input  wire  logic                       MCLK,
   input  wire  logic                       RST,
   input  wire  logic                       HW_STANDBY,
   // register port
   input  wire  logic [15:0]                ADDR,
   input  wire  logic [7:0]                 WDATA,
   input  wire  logic                       WR,
   input  wire  logic                       RD,
   output var   logic [7:0]                 RDATA,
   // timer channel settings and compare outputs
   input  wire  pagtm_pkg::pagtm_chan_cfg_t  CH2_CFG,
   input  wire  pagtm_pkg::pagtm_chan_cfg_t  CH1_CFG,
   input  wire  pagtm_pkg::pagtm_chan_pins_t CH2_CMP,
   input  wire  pagtm_pkg::pagtm_chan_pins_t CH1_CMP,
   // capture levels back to the timer
   output var   pagtm_pkg::pagtm_chan_pins_t CH2_CAP,
   output var   pagtm_pkg::pagtm_chan_pins_t CH1_CAP,
   // pattern generator
   input  wire  logic [7:0]                 PATTERN_ENABLE,
   input  wire  logic [7:0]                 PATTERN_DATA,
   // pins
   input  wire  logic [7:0]                 PIN_IN,
   output var   logic [7:0]                 PIN_OUT,
   output var   logic [7:0]                 PIN_OE_N
);
   import pagtm_pkg::*;

   logic [7:0] direction;
   logic [7:0] out_latch;

   // compare ownership of the select field: 1..3
   function automatic logic sel_compare(input logic [2:0] sel);
      sel_compare = !sel[SEL_TOP_BIT] && (sel != SEL_NONE);
   endfunction : sel_compare

   // address decode
   wire hit_dir   = (ADDR == PORT_A_DIRECTION_ADDR);
   wire hit_latch = (ADDR == PORT_A_OUTPUT_LATCH_ADDR);
   wire wr_dir    = WR && hit_dir;
   wire wr_latch  = WR && hit_latch;
   wire clear     = RST || HW_STANDBY;

   // register next values; nothing else touches them, so they hold in software standby
   wire [7:0] next_direction = clear ? PORT_A_DIRECTION_RST :
                               wr_dir ? WDATA : direction;
   wire [7:0] next_out_latch = clear ? PORT_A_OUTPUT_LATCH_RST :
                               wr_latch ? WDATA : out_latch;

   // read-back: direction-1 pins give the latch, direction-0 pins the pin level
   wire [7:0] port_view  = (direction & out_latch)
                         | (~direction & PIN_IN);
   wire [7:0] next_rdata = !RD ? 8'h00 :
                           hit_dir ? DIRECTION_READ_VALUE :
                           hit_latch ? port_view : UNMAPPED_READ_VALUE;

   // timer ownership of the shared pins, settings taken live from the timer
   wire own_ch2_b = sel_compare(CH2_CFG.b_select);
   wire own_ch2_a = CH2_CFG.pwm_mode || sel_compare(CH2_CFG.a_select);
   wire own_ch1_b = sel_compare(CH1_CFG.b_select);
   wire own_ch1_a = CH1_CFG.pwm_mode || sel_compare(CH1_CFG.a_select);
   wire [7:0] timer_own = {own_ch2_b, own_ch2_a, own_ch1_b, own_ch1_a, 4'h0};
   wire [7:0] timer_val = {CH2_CMP.b, CH2_CMP.a, CH1_CMP.b, CH1_CMP.a, 4'h0};

   // port side: latch or pattern bit on output pins
   wire [7:0] port_val = (PATTERN_ENABLE & PATTERN_DATA)
                       | (~PATTERN_ENABLE & out_latch);

   wire [7:0] next_pin_out  = (timer_own & timer_val) | (~timer_own & port_val);
   wire [7:0] next_pin_oe_n = ~(timer_own | direction);

   // capture routing: B needs top select bit and no pwm, A only the top bit
   wire next_cap2_b = CH2_CFG.b_select[SEL_TOP_BIT] && !CH2_CFG.pwm_mode
                      && PIN_IN[PIN_CH2_B];
   wire next_cap1_b = CH1_CFG.b_select[SEL_TOP_BIT] && !CH1_CFG.pwm_mode
                      && PIN_IN[PIN_CH1_B];
   wire next_cap2_a = CH2_CFG.a_select[SEL_TOP_BIT] && PIN_IN[PIN_CH2_A];
   wire next_cap1_a = CH1_CFG.a_select[SEL_TOP_BIT] && PIN_IN[PIN_CH1_A];

   always_ff @(posedge MCLK)
   begin
      direction <= next_direction;
      out_latch <= next_out_latch;
   end

   // all outputs registered; pins released and read data zero during reset
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         RDATA    <= 8'h00;
         PIN_OUT  <= 8'h00;
         PIN_OE_N <= 8'hff;
         CH2_CAP  <= '0;
         CH1_CAP  <= '0;
      end
      else
      begin
         RDATA    <= next_rdata;
         PIN_OUT  <= next_pin_out;
         PIN_OE_N <= next_pin_oe_n;
         CH2_CAP  <= '{a: next_cap2_a, b: next_cap2_b};
         CH1_CAP  <= '{a: next_cap1_a, b: next_cap1_b};
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   a_dir_sets_oe: assert property (
      PIN_OE_N[3:0] == ~$past(direction[3:0]))
      else $error("low pin enable does not follow direction");

   a_dir_reads_ones: assert property (
      RD && ADDR == PORT_A_DIRECTION_ADDR |=> RDATA == DIRECTION_READ_VALUE)
      else $error("direction read did not return all ones");

   a_clear_dir_latch: assert property (
      $past(HW_STANDBY) |-> direction == 8'h00 && out_latch == 8'h00)
      else $error("standby did not clear the registers");

   a_regs_hold: assert property (
      !HW_STANDBY && !WR |=> $stable(direction) && $stable(out_latch))
      else $error("registers changed without a write");

   a_latch_readback: assert property (
      RD && hit_latch |=> (RDATA & $past(direction)) == ($past(out_latch) & $past(direction)))
      else $error("output pin read did not return the latch");

   a_pin_readback: assert property (
      RD && hit_latch |=> (RDATA & ~$past(direction)) == ($past(PIN_IN) & ~$past(direction)))
      else $error("input pin read did not return the pin level");

   a_pin7_compare: assert property (
      CH2_CFG.b_select inside {3'h1, 3'h2, 3'h3}
      |=> !PIN_OE_N[7] && PIN_OUT[7] == $past(CH2_CMP.b))
      else $error("pin 7 not driven by channel 2 B compare");

   a_pattern_drive: assert property (
      direction[0] && PATTERN_ENABLE[0] |=> !PIN_OE_N[0] && PIN_OUT[0] == $past(PATTERN_DATA[0]))
      else $error("pin 0 not driven by pattern bit");

   a_b_capture: assert property (
      CH1_CFG.b_select[2] && !CH1_CFG.pwm_mode |=> CH1_CAP.b == $past(PIN_IN[5]))
      else $error("pin 5 level not routed to B capture");

   a_pin6_compare: assert property (
      CH2_CFG.pwm_mode |=> !PIN_OE_N[6] && PIN_OUT[6] == $past(CH2_CMP.a))
      else $error("pin 6 not driven by channel 2 A compare");

   a_a_capture: assert property (
      CH2_CFG.a_select[2] |=> CH2_CAP.a == $past(PIN_IN[6]))
      else $error("pin 6 level not routed to A capture");

   a_pin5_port: assert property (
      CH1_CFG.b_select == 3'h0 && !direction[5] |=> PIN_OE_N[5])
      else $error("pin 5 not an input when unowned and direction 0");

   a_pin4_compare: assert property (
      CH1_CFG.a_select inside {3'h1, 3'h2, 3'h3} |=> PIN_OUT[4] == $past(CH1_CMP.a))
      else $error("pin 4 not driven by channel 1 A compare");

   // register writes and holds
   a_dir_write: assert property (
      WR && hit_dir && !HW_STANDBY |=> direction == $past(WDATA))
      else $error("direction write did not land");

   a_latch_write: assert property (
      WR && hit_latch && !HW_STANDBY |=> out_latch == $past(WDATA))
      else $error("latch write did not land");

   a_dir_hold_other: assert property (
      WR && !hit_dir && !HW_STANDBY |=> $stable(direction))
      else $error("direction changed on another address");

   a_standby_latch: assert property (
      $past(HW_STANDBY) |-> out_latch == PORT_A_OUTPUT_LATCH_RST)
      else $error("standby did not clear the latch");

   // read port
   a_rdata_idle: assert property (
      !RD |=> RDATA == 8'h00)
      else $error("read data not zero without a read");

   a_unmapped_read: assert property (
      RD && !hit_dir && !hit_latch |=> RDATA == UNMAPPED_READ_VALUE)
      else $error("unmapped read returned wrong value");

   a_all_out_read: assert property (
      RD && hit_latch && direction == 8'hff |=> RDATA == $past(out_latch))
      else $error("all-output read did not return the latch");

   a_all_in_read: assert property (
      RD && hit_latch && direction == 8'h00 |=> RDATA == $past(PIN_IN))
      else $error("all-input read did not return the pins");

   // plain port pins 3..0
   a_latch_drive: assert property (
      direction[1] && !PATTERN_ENABLE[1]
      |=> !PIN_OE_N[1] && PIN_OUT[1] == $past(out_latch[1]))
      else $error("pin 1 not driven by the latch");

   a_input_release: assert property (
      !direction[2] |=> PIN_OE_N[2])
      else $error("pin 2 driven with direction 0");

   a_pin3_release: assert property (
      !direction[3] |=> PIN_OE_N[3])
      else $error("pin 3 driven with direction 0");

   a_pin3_latch: assert property (
      direction[3] && !PATTERN_ENABLE[3] |=> PIN_OUT[3] == $past(out_latch[3]))
      else $error("pin 3 not driven by the latch");

   a_pin2_pattern: assert property (
      direction[2] && PATTERN_ENABLE[2] |=> PIN_OUT[2] == $past(PATTERN_DATA[2]))
      else $error("pin 2 not driven by pattern bit");

   // pin 7
   a_pin7_over_dir: assert property (
      CH2_CFG.b_select inside {3'h1, 3'h2, 3'h3} && !direction[7] |=> !PIN_OE_N[7])
      else $error("pin 7 compare did not override direction");

   a_pin7_port: assert property (
      !(CH2_CFG.b_select inside {3'h1, 3'h2, 3'h3}) && !direction[7] |=> PIN_OE_N[7])
      else $error("pin 7 not an input when unowned");

   a_pin7_pwm_free: assert property (
      CH2_CFG.pwm_mode && CH2_CFG.b_select == 3'h0 && !direction[7] |=> PIN_OE_N[7])
      else $error("pwm alone took pin 7");

   a_pin7_latch: assert property (
      !(CH2_CFG.b_select inside {3'h1, 3'h2, 3'h3}) && direction[7] && !PATTERN_ENABLE[7]
      |=> !PIN_OE_N[7] && PIN_OUT[7] == $past(out_latch[7]))
      else $error("pin 7 not driven by the latch");

   a_pin7_pattern: assert property (
      !(CH2_CFG.b_select inside {3'h1, 3'h2, 3'h3}) && direction[7] && PATTERN_ENABLE[7]
      |=> !PIN_OE_N[7] && PIN_OUT[7] == $past(PATTERN_DATA[7]))
      else $error("pin 7 not driven by pattern bit");

   // pin 6
   a_pin6_select: assert property (
      CH2_CFG.a_select inside {3'h1, 3'h2, 3'h3}
      |=> !PIN_OE_N[6] && PIN_OUT[6] == $past(CH2_CMP.a))
      else $error("pin 6 not driven by A select compare");

   a_pin6_port: assert property (
      !CH2_CFG.pwm_mode && !(CH2_CFG.a_select inside {3'h1, 3'h2, 3'h3}) && !direction[6]
      |=> PIN_OE_N[6])
      else $error("pin 6 not an input when unowned");

   a_pin6_pattern: assert property (
      !CH2_CFG.pwm_mode && !(CH2_CFG.a_select inside {3'h1, 3'h2, 3'h3})
      && direction[6] && PATTERN_ENABLE[6]
      |=> !PIN_OE_N[6] && PIN_OUT[6] == $past(PATTERN_DATA[6]))
      else $error("pin 6 not driven by pattern bit");

   // pin 5
   a_pin5_compare: assert property (
      CH1_CFG.b_select inside {3'h1, 3'h2, 3'h3}
      |=> !PIN_OE_N[5] && PIN_OUT[5] == $past(CH1_CMP.b))
      else $error("pin 5 not driven by channel 1 B compare");

   a_pin5_latch: assert property (
      !(CH1_CFG.b_select inside {3'h1, 3'h2, 3'h3}) && direction[5] && !PATTERN_ENABLE[5]
      |=> !PIN_OE_N[5] && PIN_OUT[5] == $past(out_latch[5]))
      else $error("pin 5 not driven by the latch");

   // pin 4
   a_pin4_pwm: assert property (
      CH1_CFG.pwm_mode |=> !PIN_OE_N[4] && PIN_OUT[4] == $past(CH1_CMP.a))
      else $error("pin 4 not driven under channel 1 pwm");

   a_pin4_over_pat: assert property (
      CH1_CFG.a_select inside {3'h1, 3'h2, 3'h3} && PATTERN_ENABLE[4]
      |=> PIN_OUT[4] == $past(CH1_CMP.a))
      else $error("pattern bit overrode pin 4 compare");

   a_pin4_port: assert property (
      !CH1_CFG.pwm_mode && !(CH1_CFG.a_select inside {3'h1, 3'h2, 3'h3}) && !direction[4]
      |=> PIN_OE_N[4])
      else $error("pin 4 not an input when unowned");

   a_pin4_pattern: assert property (
      !CH1_CFG.pwm_mode && !(CH1_CFG.a_select inside {3'h1, 3'h2, 3'h3})
      && direction[4] && PATTERN_ENABLE[4]
      |=> !PIN_OE_N[4] && PIN_OUT[4] == $past(PATTERN_DATA[4]))
      else $error("pin 4 not driven by pattern bit");

   // capture routing
   a_b2_capture: assert property (
      CH2_CFG.b_select[2] && !CH2_CFG.pwm_mode |=> CH2_CAP.b == $past(PIN_IN[7]))
      else $error("pin 7 level not routed to B capture");

   a_b2_no_cap: assert property (
      !CH2_CFG.b_select[2] || CH2_CFG.pwm_mode |=> !CH2_CAP.b)
      else $error("channel 2 B capture fed when not selected");

   a_b1_no_cap: assert property (
      !CH1_CFG.b_select[2] || CH1_CFG.pwm_mode |=> !CH1_CAP.b)
      else $error("channel 1 B capture fed when not selected");

   a_a1_capture: assert property (
      CH1_CFG.a_select[2] |=> CH1_CAP.a == $past(PIN_IN[4]))
      else $error("pin 4 level not routed to A capture");

   a_a2_pwm_cap: assert property (
      CH2_CFG.pwm_mode && CH2_CFG.a_select[2] |=> CH2_CAP.a == $past(PIN_IN[6]))
      else $error("pin 6 capture lost under pwm");

   a_a2_no_cap: assert property (
      !CH2_CFG.a_select[2] |=> !CH2_CAP.a)
      else $error("channel 2 A capture fed when not selected");

   a_a1_no_cap: assert property (
      !CH1_CFG.a_select[2] |=> !CH1_CAP.a)
      else $error("channel 1 A capture fed when not selected");

   c_latch_write_read: cover property (wr_latch ##1 RD && hit_latch);
   c_pin7_owned: cover property (own_ch2_b && direction[7]);
   c_pattern_pin6: cover property (!own_ch2_a && direction[6] && PATTERN_ENABLE[6]);
   c_hw_standby: cover property (HW_STANDBY ##1 !HW_STANDBY);
   c_pwm_pin4: cover property (CH1_CFG.pwm_mode && PATTERN_ENABLE[4] && direction[4]);

endmodule : pagtm_port_a

`default_nettype wire

// *** dv/pagtm_board.sv ***
// board model: resolves the shared pin wires from the port drive and outside drivers
`timescale 1ns/1ps
`default_nettype none

module pagtm_board
(
   // port side
   input  wire logic [7:0] PIN_OUT,
   input  wire logic [7:0] PIN_OE_N,
   // outside drivers, seen only where the port lets go of the pin
   input  wire logic [7:0] EXT_LEVEL,
   output var  logic [7:0] PIN_IN
);
   // a driving port owns the wire, a released pin shows the outside level
   assign PIN_IN = (~PIN_OE_N & PIN_OUT) | (PIN_OE_N & EXT_LEVEL);
endmodule : pagtm_board

`default_nettype wire

// *** dv/testbench.sv ***
// testbench: random register and pin traffic checked against a cycle model of port a
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import pagtm_pkg::*;
   typedef struct packed {logic [7:0] rd; logic [7:0] po; logic [7:0] oe; logic [3:0] cap;} pagtm_exp_t;
   logic             mclk = 1'b0, rst = 1'b1, hw_standby = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0]      addr = 16'h0000;
   logic [7:0]       wdata = 8'h00, pat_en = 8'h00, pat_dat = 8'h00, ext = 8'h00;
   logic [7:0]       rdata, pin_in, pin_out, pin_oe_n, dir_m, lat_m, own8;
   pagtm_chan_cfg_t  ch2_cfg = '0, ch1_cfg = '0;
   pagtm_chan_pins_t ch2_cmp = '0, ch1_cmp = '0, ch2_cap, ch1_cap;
   pagtm_exp_t       e, q[$];
   int               err_count = 0, n_compared = 0, cycles = 0;
   integer           seed = 32'hf45fa87f;
   logic [31:0]      r, r2;

   pagtm_port_a pagtm_port_a_inst (.MCLK(mclk), .RST(rst), .HW_STANDBY(hw_standby), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CH2_CFG(ch2_cfg), .CH1_CFG(ch1_cfg),
      .CH2_CMP(ch2_cmp), .CH1_CMP(ch1_cmp), .CH2_CAP(ch2_cap), .CH1_CAP(ch1_cap),
      .PATTERN_ENABLE(pat_en), .PATTERN_DATA(pat_dat), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE_N(pin_oe_n));
   pagtm_board pagtm_board_inst (.PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .EXT_LEVEL(ext),
      .PIN_IN(pin_in));

   always #4 mclk = ~mclk;

   // {b owned, a owned} by the timer compare outputs
   function automatic logic [1:0] own(input pagtm_chan_cfg_t c);
      own = {c.b_select != SEL_NONE && !c.b_select[SEL_TOP_BIT],
             c.pwm_mode || (c.a_select != SEL_NONE && !c.a_select[SEL_TOP_BIT])};
   endfunction : own

   // capture levels {a, b}; p is {b pin, a pin}
   function automatic logic [1:0] cap(input pagtm_chan_cfg_t c, input logic [1:0] p);
      cap = {p[0] & c.a_select[SEL_TOP_BIT], p[1] & c.b_select[SEL_TOP_BIT] & !c.pwm_mode};
   endfunction : cap

   // one compare of an 8-bit view, printing its own mismatch line
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : check8

   task automatic finish_test();
      if (err_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // note what the outputs must show after this edge, then move the register mirror
   always @(posedge mclk)
   begin
      own8 = {own(ch2_cfg), own(ch1_cfg), 4'h0};
      e.oe = ~(own8 | dir_m);
      e.po = (own8 & {ch2_cmp.b, ch2_cmp.a, ch1_cmp.b, ch1_cmp.a, 4'h0})
           | (~own8 & ((pat_en & pat_dat) | (~pat_en & lat_m)));
      e.cap = {cap(ch2_cfg, pin_in[7:6]), cap(ch1_cfg, pin_in[5:4])};
      e.rd = !rd ? 8'h00 : addr == PORT_A_DIRECTION_ADDR ? DIRECTION_READ_VALUE
           : addr == PORT_A_OUTPUT_LATCH_ADDR ? ((dir_m & lat_m) | (~dir_m & pin_in))
           : UNMAPPED_READ_VALUE;
      if (rst)
         e = '{8'h00, 8'h00, 8'hff, 4'h0};
      q.push_back(e);
      if (rst || hw_standby)
      begin
         dir_m = PORT_A_DIRECTION_RST;
         lat_m = PORT_A_OUTPUT_LATCH_RST;
      end
      else if (wr && addr == PORT_A_DIRECTION_ADDR)
         dir_m = wdata;
      else if (wr && addr == PORT_A_OUTPUT_LATCH_ADDR)
         lat_m = wdata;
   end

   // settled outputs are compared against the oldest note
   always @(negedge mclk)
   begin
      if (q.size() > 0)
      begin
         e = q.pop_front();
         check8(rdata, e.rd);
         check8(pin_oe_n, e.oe);
         check8(pin_out & ~e.oe, e.po & ~e.oe);
         check8({4'h0, ch2_cap, ch1_cap}, {4'h0, e.cap});
      end
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         err_count++;
         finish_test();
      end
   end

   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge mclk);
         r = $random(seed);
         r2 = $random(seed);
         wr <= r[1:0] == 2'h1;
         rd <= r[1:0] == 2'h2;
         addr <= r[3] ? PORT_A_OUTPUT_LATCH_ADDR : r[2] ? PORT_A_DIRECTION_ADDR : 16'hffd5;
         wdata <= r[15:8];
         hw_standby <= r[22:16] == 7'h00;
         rst <= i >= 1500 && i < 1503;
         pat_en <= r[31:24];
         pat_dat <= r2[7:0];
         ext <= r2[15:8];
         ch2_cfg <= r2[22:16];
         ch1_cfg <= r2[29:23];
         ch2_cmp <= r2[31:30];
         ch1_cmp <= r[5:4];
      end
      repeat (2) @(posedge mclk);
      finish_test();
   end
endmodule : testbench

`default_nettype wire

// *** shared/pagtm_pkg.sv ***
// package: register map, field layout and timer-setting carriers of the port block
package pagtm_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;

   // register byte addresses (lower 16 bits)
   localparam logic [15:0] PORT_A_DIRECTION_ADDR    = 16'hffd1;
   localparam logic [15:0] PORT_A_OUTPUT_LATCH_ADDR = 16'hffd3;

   // reset values
   localparam logic [7:0] PORT_A_DIRECTION_RST    = 8'h00;
   localparam logic [7:0] PORT_A_OUTPUT_LATCH_RST = 8'h00;

   // a read of the write-only direction register
   localparam logic [7:0] DIRECTION_READ_VALUE = 8'hff;
   // answer to a read of an unmapped address
   localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

   // pin positions of the timer-shared pins
   localparam int unsigned PIN_CH2_B = 7;
   localparam int unsigned PIN_CH2_A = 6;
   localparam int unsigned PIN_CH1_B = 5;
   localparam int unsigned PIN_CH1_A = 4;

   // i/o-select field: top bit picks capture, top bit 0 with low bits nonzero picks compare
   localparam int unsigned SEL_TOP_BIT = 2;
   localparam logic [2:0]  SEL_NONE    = 3'h0;

   // settings of one timer channel, as seen by the port
   typedef struct packed {
      logic       pwm_mode;
      logic [2:0] a_select;
      logic [2:0] b_select;
   } pagtm_chan_cfg_t;

   // compare outputs of one timer channel, and capture inputs to it
   typedef struct packed {
      logic a;
      logic b;
   } pagtm_chan_pins_t;

endpackage : pagtm_pkg
